// [common/phc_hdr_if.sv]
// carrier between the framer and its header byte checker
`timescale 1ns/1ps
`default_nettype none
interface phc_hdr_if;
  logic [7:0] hbyte;
  logic [1:0] idx;
  logic [31:0] chk;
  logic [3:0] hdch;
  logic [3:0] bcen;
  logic pass;
  modport framer (output hbyte, idx, chk, hdch, bcen, input pass);
  modport judge (input hbyte, idx, chk, hdch, bcen, output pass);
endinterface
`default_nettype wire

// [common/phc_pkg.sv]
// constants shared by the packet handler control block
package phc_pkg;
  // word indices; byte address is four times the index
  localparam logic [7:0] IDX_CFG = 8'h30;
  localparam logic [7:0] IDX_STAT = 8'h31;
  localparam logic [7:0] IDX_HCTL = 8'h32;
  localparam logic [7:0] IDX_CHK = 8'h40;
  localparam logic [7:0] IDX_TXH = 8'h41;
  localparam logic [7:0] IDX_MISC = 8'h42;
  localparam logic [7:0] IDX_CLR = 8'h43;
  // config fields
  localparam int CFG_RXEN = 7;
  localparam int CFG_LSB = 6;
  localparam int CFG_DONLY = 5;
  localparam int CFG_TXEN = 3;
  localparam int CFG_CRCEN = 2;
  localparam int CFG_POLY = 0;
  // status / clear fields
  localparam int ST_ONES = 6;
  localparam int ST_SRCH = 5;
  localparam int ST_RX = 4;
  localparam int ST_VALID = 3;
  localparam int ST_CRCERR = 2;
  localparam int ST_TX = 1;
  localparam int ST_SENT = 0;
  // header control fields
  localparam int HC_BCEN = 4;
  localparam int HC_HDCH = 0;
  // misc fields
  localparam int MI_MODE = 0;
  localparam int MI_HDLEN = 4;
  localparam int MI_PLEN = 8;
  localparam logic [1:0] MODE_FIFO = 2'h2;
  localparam logic [2:0] HDR_MAX = 3'h4;
  // reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] HCTL_RST = 8'h00;
  localparam logic [31:0] CHK_RST = 32'h00000000;
  localparam logic [31:0] TXH_RST = 32'h00000000;
  localparam logic [15:0] MISC_RST = 16'h0000;
  // crc, broadcast byte and last bit of a byte
  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] POLY_IBM = 16'h8005;
  localparam logic [15:0] POLY_IEC = 16'h3d65;
  localparam logic [15:0] POLY_BIA = 16'h8bb7;
  localparam logic [15:0] CRC_SEED = 16'h0000;
  localparam logic [15:0] CRC_ONES = 16'hffff;
  localparam logic [3:0] CRC_LAST = 4'hf;
  localparam logic [7:0] BCAST = 8'hff;
  localparam logic [2:0] BIT_LAST = 3'h7;
endpackage

// [logic/phc_hdr_check.sv]
// per-byte received header check with broadcast acceptance
`timescale 1ns/1ps
`default_nettype none
module phc_hdr_check #(
  parameter int NBYTES = 4
) (
  phc_hdr_if.judge hif
);
  logic [NBYTES-1:0] ok;
  for (genvar i = 0; i < NBYTES; i++) begin : g_byte
    // an unchecked byte always passes
    assign ok[i] = !hif.hdch[i] ||
      (hif.hbyte == hif.chk[i*8 +: 8]) ||
      (hif.bcen[i] && hif.hbyte == phc_pkg::BCAST);
  end
  assign hif.pass = ok[hif.idx];
endmodule
`default_nettype wire

// [logic/phc_top.sv]
// packet handler control: registers, framer and deframer
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module phc_top #(
  parameter int ADR_W = 12
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [ADR_W-1:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic wb_we_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic rx_en_in,
  input wire logic rx_sync_in,
  input wire logic rx_bit_in,
  input wire logic rx_bit_valid_in,
  output logic [7:0] rx_byte_out,
  output logic rx_byte_valid_out,
  input wire logic tx_start_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_byte_valid_in,
  output logic tx_pop_out,
  input wire logic tx_bit_ready_in,
  output logic tx_bit_out,
  output logic tx_bit_valid_out
);
  typedef enum logic [2:0] {
    S_IDLE, S_RX_RAW, S_RX_HDR, S_RX_DATA, S_RX_CRC,
    S_TX_HDR, S_TX_DATA, S_TX_CRC
  } phc_state_t;

  typedef struct packed {
    phc_state_t st;
    logic [7:0] cfg;
    logic [7:0] hctl;
    logic [31:0] chk;
    logic [31:0] txh;
    logic [15:0] misc;
    logic [7:0] sh;
    logic [2:0] bcnt;
    logic [1:0] idx;
    logic [7:0] dcnt;
    logic [15:0] crc;
    logic [15:0] rcrc;
    logic [3:0] ccnt;
    logic have;
    logic pk;
    logic valid;
    logic crcerr;
    logic sent;
    logic ones;
    logic ack;
    logic [31:0] dat;
    logic [7:0] rxb;
    logic rxv;
    logic txbit;
    logic txv;
    logic pop;
  } phc_regs_t;

  localparam phc_regs_t REGS_RST = '{
    st: S_IDLE, cfg: phc_pkg::CFG_RST, hctl: phc_pkg::HCTL_RST,
    chk: phc_pkg::CHK_RST, txh: phc_pkg::TXH_RST,
    misc: phc_pkg::MISC_RST, crc: phc_pkg::CRC_SEED,
    default: '0
  };

  phc_regs_t s_r;
  phc_regs_t s_nxt;

  phc_hdr_if hif ();
  phc_hdr_check #(.NBYTES(4)) u_chk (.hif(hif));

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic b,
                                           input logic [15:0] p);
    crc_step = {c[14:0], 1'b0} ^ (p & {16{c[15] ^ b}});
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o,
                                         input logic [31:0] w,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = w[i*8 +: 8];
      end
    end
    wmerge = r;
  endfunction

  logic lsb;
  logic donly;
  logic crcen;
  logic pkt_rx;
  logic pkt_tx;
  logic [15:0] poly;
  logic [2:0] hdlen;
  logic [1:0] hdr_last;
  logic [7:0] plen;
  logic [7:0] bnew;
  logic [7:0] shout;
  logic obit;
  logic srch;
  logic rxing;
  logic txing;
  logic [7:0] stat;
  logic [31:0] rdata;
  logic hit;
  logic [7:0] widx;

  assign lsb = s_r.cfg[phc_pkg::CFG_LSB];
  assign donly = s_r.cfg[phc_pkg::CFG_DONLY];
  assign crcen = s_r.cfg[phc_pkg::CFG_CRCEN];
  assign pkt_rx = s_r.misc[phc_pkg::MI_MODE +: 2] == phc_pkg::MODE_FIFO &&
    s_r.cfg[phc_pkg::CFG_RXEN];
  assign pkt_tx = s_r.misc[phc_pkg::MI_MODE +: 2] == phc_pkg::MODE_FIFO &&
    s_r.cfg[phc_pkg::CFG_TXEN];
  // lengths above the largest header are taken as the full header
  assign hdlen = (s_r.misc[phc_pkg::MI_HDLEN +: 3] > phc_pkg::HDR_MAX) ?
    phc_pkg::HDR_MAX : s_r.misc[phc_pkg::MI_HDLEN +: 3];
  assign hdr_last = 2'(phc_pkg::HDR_MAX - hdlen);
  assign plen = s_r.misc[phc_pkg::MI_PLEN +: 8];

  always_comb begin
    case (s_r.cfg[phc_pkg::CFG_POLY +: 2])
      2'h0: poly = phc_pkg::POLY_CCITT;
      2'h1: poly = phc_pkg::POLY_IBM;
      2'h2: poly = phc_pkg::POLY_IEC;
      default: poly = phc_pkg::POLY_BIA;
    endcase
  end

  // shift direction follows the bit-order control on both paths
  assign bnew = lsb ? {rx_bit_in, s_r.sh[7:1]} :
    {s_r.sh[6:0], rx_bit_in};
  assign obit = lsb ? s_r.sh[0] : s_r.sh[7];
  assign shout = lsb ? {1'b0, s_r.sh[7:1]} : {s_r.sh[6:0], 1'b0};

  assign hif.hbyte = bnew;
  assign hif.idx = s_r.idx;
  assign hif.chk = s_r.chk;
  assign hif.hdch = s_r.hctl[phc_pkg::HC_HDCH +: 4];
  assign hif.bcen = s_r.hctl[phc_pkg::HC_BCEN +: 4];

  assign srch = pkt_rx && rx_en_in && s_r.st == S_IDLE;
  assign rxing = s_r.st == S_RX_HDR || s_r.st == S_RX_DATA ||
    s_r.st == S_RX_CRC;
  assign txing = s_r.pk && (s_r.st == S_TX_HDR || s_r.st == S_TX_DATA ||
    s_r.st == S_TX_CRC);
  assign stat = {1'b0, s_r.ones, srch, rxing, s_r.valid, s_r.crcerr,
    txing, s_r.sent};

  // upper address bits and the two low address bits must be zero, anything else reads as zero
  assign hit = wb_adr_in[ADR_W-1:10] == '0 && wb_adr_in[1:0] == 2'h0;
  assign widx = wb_adr_in[9:2];

  always_comb begin
    rdata = '0;
    if (hit) begin
      case (widx)
        phc_pkg::IDX_CFG: rdata[7:0] = s_r.cfg;
        phc_pkg::IDX_STAT: rdata[7:0] = stat;
        phc_pkg::IDX_HCTL: rdata[7:0] = s_r.hctl;
        phc_pkg::IDX_CHK: rdata = s_r.chk;
        phc_pkg::IDX_TXH: rdata = s_r.txh;
        phc_pkg::IDX_MISC: rdata[15:0] = s_r.misc;
        default: rdata = '0;
      endcase
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.rxv = 1'b0;
    s_nxt.txv = 1'b0;
    s_nxt.pop = 1'b0;
    // bus slave; reads carry no side effect on any flag
    if (wb_cyc_in && wb_stb_in && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      s_nxt.dat = rdata;
      if (wb_we_in && hit) begin
        case (widx)
          phc_pkg::IDX_CFG: begin
            if (wb_sel_in[0]) begin
              s_nxt.cfg = wb_dat_in[7:0];
            end
          end
          phc_pkg::IDX_HCTL: begin
            if (wb_sel_in[0]) begin
              s_nxt.hctl = wb_dat_in[7:0];
            end
          end
          phc_pkg::IDX_CHK: s_nxt.chk = wmerge(s_r.chk, wb_dat_in, wb_sel_in);
          phc_pkg::IDX_TXH: s_nxt.txh = wmerge(s_r.txh, wb_dat_in, wb_sel_in);
          phc_pkg::IDX_MISC: begin
            s_nxt.misc = 16'(wmerge({16'h0000, s_r.misc}, wb_dat_in,
              wb_sel_in));
          end
          phc_pkg::IDX_CLR: begin
            // write one to clear; the framer below runs later so a
            // same-cycle set wins
            if (wb_sel_in[0]) begin
              s_nxt.valid = s_r.valid & ~wb_dat_in[phc_pkg::ST_VALID];
              s_nxt.crcerr = s_r.crcerr & ~wb_dat_in[phc_pkg::ST_CRCERR];
              s_nxt.sent = s_r.sent & ~wb_dat_in[phc_pkg::ST_SENT];
              s_nxt.ones = s_r.ones & ~wb_dat_in[phc_pkg::ST_ONES];
            end
          end
          default: ;
        endcase
      end
    end

    case (s_r.st)
      S_IDLE: begin
        s_nxt.bcnt = '0;
        s_nxt.ccnt = '0;
        s_nxt.crc = phc_pkg::CRC_SEED;
        s_nxt.rcrc = '0;
        s_nxt.have = 1'b0;
        s_nxt.idx = 2'h3;
        s_nxt.dcnt = plen;
        if (rx_en_in && rx_sync_in) begin
          if (!pkt_rx) begin
            s_nxt.st = S_RX_RAW;
          end else if (hdlen != 3'h0) begin
            s_nxt.st = S_RX_HDR;
          end else if (plen != 8'h00) begin
            s_nxt.st = S_RX_DATA;
          end else if (crcen) begin
            s_nxt.st = S_RX_CRC;
          end else begin
            s_nxt.valid = 1'b1;
          end
        end else if (tx_start_in && !rx_en_in) begin
          s_nxt.pk = pkt_tx;
          if (!pkt_tx) begin
            s_nxt.st = S_TX_DATA;
          end else if (hdlen != 3'h0) begin
            s_nxt.st = S_TX_HDR;
            s_nxt.sh = s_r.txh[{2'h3, 3'h0} +: 8];
            s_nxt.have = 1'b1;
          end else if (plen != 8'h00) begin
            s_nxt.st = S_TX_DATA;
          end else if (crcen) begin
            s_nxt.st = S_TX_CRC;
          end else begin
            s_nxt.sent = 1'b1;
          end
        end
      end
      S_RX_RAW: begin
        if (!rx_en_in) begin
          s_nxt.st = S_IDLE;
        end else if (rx_bit_valid_in) begin
          s_nxt.sh = bnew;
          s_nxt.bcnt = s_r.bcnt + 3'h1;
          if (s_r.bcnt == phc_pkg::BIT_LAST) begin
            s_nxt.rxb = bnew;
            s_nxt.rxv = 1'b1;
          end
        end
      end
      S_RX_HDR: begin
        if (!rx_en_in) begin
          s_nxt.st = S_IDLE;
        end else if (rx_bit_valid_in) begin
          s_nxt.sh = bnew;
          s_nxt.bcnt = s_r.bcnt + 3'h1;
          if (!donly) begin
            s_nxt.crc = crc_step(s_r.crc, rx_bit_in, poly);
          end
          if (s_r.bcnt == phc_pkg::BIT_LAST) begin
            if (!hif.pass) begin
              s_nxt.st = S_IDLE;
            end else if (s_r.idx != hdr_last) begin
              s_nxt.idx = s_r.idx - 2'h1;
            end else if (plen != 8'h00) begin
              s_nxt.st = S_RX_DATA;
            end else if (crcen) begin
              s_nxt.st = S_RX_CRC;
            end else begin
              s_nxt.valid = 1'b1;
              s_nxt.st = S_IDLE;
            end
          end
        end
      end
      S_RX_DATA: begin
        if (!rx_en_in) begin
          s_nxt.st = S_IDLE;
        end else if (rx_bit_valid_in) begin
          s_nxt.sh = bnew;
          s_nxt.bcnt = s_r.bcnt + 3'h1;
          s_nxt.crc = crc_step(s_r.crc, rx_bit_in, poly);
          if (s_r.bcnt == phc_pkg::BIT_LAST) begin
            s_nxt.rxb = bnew;
            s_nxt.rxv = 1'b1;
            s_nxt.dcnt = s_r.dcnt - 8'h01;
            if (s_r.dcnt == 8'h01) begin
              if (crcen) begin
                s_nxt.st = S_RX_CRC;
              end else begin
                s_nxt.valid = 1'b1;
                s_nxt.st = S_IDLE;
              end
            end
          end
        end
      end
      S_RX_CRC: begin
        // crc field always arrives most significant bit first
        if (!rx_en_in) begin
          s_nxt.st = S_IDLE;
        end else if (rx_bit_valid_in) begin
          s_nxt.rcrc = {s_r.rcrc[14:0], rx_bit_in};
          s_nxt.ccnt = s_r.ccnt + 4'h1;
          if (s_r.ccnt == phc_pkg::CRC_LAST) begin
            s_nxt.st = S_IDLE;
            s_nxt.ones = {s_r.rcrc[14:0], rx_bit_in} ==
              phc_pkg::CRC_ONES;
            if ({s_r.rcrc[14:0], rx_bit_in} == s_r.crc) begin
              s_nxt.valid = 1'b1;
            end else begin
              s_nxt.crcerr = 1'b1;
            end
          end
        end
      end
      S_TX_HDR: begin
        if (tx_bit_ready_in) begin
          s_nxt.txbit = obit;
          s_nxt.txv = 1'b1;
          s_nxt.sh = shout;
          s_nxt.bcnt = s_r.bcnt + 3'h1;
          if (!donly) begin
            s_nxt.crc = crc_step(s_r.crc, obit, poly);
          end
          if (s_r.bcnt == phc_pkg::BIT_LAST) begin
            if (s_r.idx != hdr_last) begin
              s_nxt.idx = s_r.idx - 2'h1;
              s_nxt.sh = s_r.txh[{s_r.idx - 2'h1, 3'h0} +: 8];
            end else begin
              s_nxt.have = 1'b0;
              if (plen != 8'h00) begin
                s_nxt.st = S_TX_DATA;
              end else if (crcen) begin
                s_nxt.st = S_TX_CRC;
              end else begin
                s_nxt.sent = 1'b1;
                s_nxt.st = S_IDLE;
              end
            end
          end
        end
      end
      S_TX_DATA: begin
        // a packet stalls on an empty fifo; raw mode ends there
        if (!s_r.have) begin
          if (tx_byte_valid_in) begin
            s_nxt.sh = tx_byte_in;
            s_nxt.have = 1'b1;
            s_nxt.pop = 1'b1;
          end else if (!s_r.pk) begin
            s_nxt.st = S_IDLE;
            s_nxt.sent = 1'b1;
          end
        end else if (tx_bit_ready_in) begin
          s_nxt.txbit = obit;
          s_nxt.txv = 1'b1;
          s_nxt.sh = shout;
          s_nxt.bcnt = s_r.bcnt + 3'h1;
          s_nxt.crc = crc_step(s_r.crc, obit, poly);
          if (s_r.bcnt == phc_pkg::BIT_LAST) begin
            s_nxt.have = 1'b0;
            if (s_r.pk) begin
              s_nxt.dcnt = s_r.dcnt - 8'h01;
              if (s_r.dcnt == 8'h01) begin
                if (crcen) begin
                  s_nxt.st = S_TX_CRC;
                end else begin
                  s_nxt.sent = 1'b1;
                  s_nxt.st = S_IDLE;
                end
              end
            end
          end
        end
      end
      S_TX_CRC: begin
        if (tx_bit_ready_in) begin
          s_nxt.txbit = s_r.crc[15];
          s_nxt.txv = 1'b1;
          s_nxt.crc = {s_r.crc[14:0], 1'b0};
          s_nxt.ccnt = s_r.ccnt + 4'h1;
          if (s_r.ccnt == phc_pkg::CRC_LAST) begin
            s_nxt.sent = 1'b1;
            s_nxt.st = S_IDLE;
          end
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_r <= REGS_RST;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_out = s_r.dat;
  assign wb_ack_out = s_r.ack;
  assign rx_byte_out = s_r.rxb;
  assign rx_byte_valid_out = s_r.rxv;
  assign tx_pop_out = s_r.pop;
  assign tx_bit_out = s_r.txbit;
  assign tx_bit_valid_out = s_r.txv;
endmodule
`default_nettype wire

// [verif/phc_monitor.sv]
// port-level assertion checker for the packet handler control block
`timescale 1ns/1ps
`default_nettype none
module phc_monitor #(
  parameter int ADR_W = 12
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic rx_en_in,
  input wire logic rx_bit_valid_in,
  input wire logic rx_byte_valid_out,
  input wire logic tx_byte_valid_in,
  input wire logic tx_pop_out,
  input wire logic tx_bit_ready_in,
  input wire logic tx_bit_valid_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_take;
    wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in;
  endsequence
  sequence s_answer;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  AST_ACK_ONE: assert property (s_take |=> s_answer)
    else $error("ack not a single pulse after request");
  AST_ACK_CAUSE: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  AST_RX_BYTE_BIT: assert property
    (rx_byte_valid_out |-> $past(rx_bit_valid_in))
    else $error("rx byte without a bit");
  AST_RX_BYTE_EN: assert property
    (rx_byte_valid_out |-> $past(rx_en_in))
    else $error("rx byte while receiver off");
  AST_RX_BYTE_GAP: assert property
    (rx_byte_valid_out |=> !rx_byte_valid_out [*7])
    else $error("rx bytes closer than eight bits");
  AST_TX_BIT_READY: assert property
    (tx_bit_valid_out |-> $past(tx_bit_ready_in))
    else $error("tx bit without ready");
  AST_TX_POP_GAP: assert property
    ($rose(tx_pop_out) |=> !tx_pop_out [*8])
    else $error("tx pops closer than a byte");
  AST_TX_POP_HEAD: assert property
    (tx_pop_out |-> $past(tx_byte_valid_in))
    else $error("pop of an empty fifo");
endmodule
bind phc_top phc_monitor #(.ADR_W(ADR_W)) u_mon (.clk_in(clk_in),
  .srst_in(srst_in), .ce_in(ce_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .rx_en_in(rx_en_in),
  .rx_bit_valid_in(rx_bit_valid_in), .rx_byte_valid_out(rx_byte_valid_out),
  .tx_byte_valid_in(tx_byte_valid_in), .tx_pop_out(tx_pop_out),
  .tx_bit_ready_in(tx_bit_ready_in), .tx_bit_valid_out(tx_bit_valid_out));
`default_nettype wire

// [verif/phc_radio_model.sv]
// remote radio: feeds received bits and takes transmitted bits
`timescale 1ns/1ps
`default_nettype none
module phc_radio_model (
  input wire logic clk_in,
  output logic sync_out,
  output logic bit_out,
  output logic bit_valid_out,
  output logic ready_out,
  input wire logic tx_bit_in,
  input wire logic tx_bit_valid_in
);
  bit txq[$];
  initial begin
    sync_out = 1'b0;
    bit_out = 1'b0;
    bit_valid_out = 1'b0;
    ready_out = 1'b0;
  end
  // random stalls so the framer must honour ready
  always @(posedge clk_in) begin
    ready_out <= ($urandom % 4) != 0;
    if (tx_bit_valid_in) txq.push_back(tx_bit_in);
  end
  // between bits the line shows the inverse, so a stale bit never passes
  task automatic send_bits(input bit q[$]);
    @(posedge clk_in);
    sync_out <= 1'b1;
    @(posedge clk_in);
    sync_out <= 1'b0;
    foreach (q[i]) begin
      bit_out <= q[i];
      bit_valid_out <= 1'b1;
      @(posedge clk_in);
      if ($urandom % 3 == 0) begin
        bit_valid_out <= 1'b0;
        bit_out <= ~q[i];
        @(posedge clk_in);
      end
    end
    bit_valid_out <= 1'b0;
    bit_out <= ~bit_out;
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the packet handler control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_in, srst_in, wb_we, wb_cyc, wb_stb, wb_ack, rx_en, rx_sync;
  logic [11:0] wb_adr;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic rx_bit, rx_bit_valid, rx_byte_valid, tx_start, tx_byte_valid;
  logic tx_pop, tx_ready, tx_bit, tx_bit_valid, lsb, donly, busy;
  logic [7:0] rx_byte, tx_byte, v, c3, h3;
  logic [15:0] crc_acc, poly;
  int failures, checked, cycles;
  bit bits[$];
  logic [7:0] rxq[$], fifoq[$], pay[$];
  localparam logic [15:0] POLYS [4] = '{phc_pkg::POLY_CCITT,
    phc_pkg::POLY_IBM, phc_pkg::POLY_IEC, phc_pkg::POLY_BIA};
  phc_top #(.ADR_W(12)) uut (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(1'b1), .wb_adr_in(wb_adr), .wb_dat_in(wb_wdat),
    .wb_sel_in(4'hf), .wb_we_in(wb_we), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
    .rx_en_in(rx_en), .rx_sync_in(rx_sync), .rx_bit_in(rx_bit),
    .rx_bit_valid_in(rx_bit_valid), .rx_byte_out(rx_byte),
    .rx_byte_valid_out(rx_byte_valid), .tx_start_in(tx_start),
    .tx_byte_in(tx_byte), .tx_byte_valid_in(tx_byte_valid),
    .tx_pop_out(tx_pop), .tx_bit_ready_in(tx_ready),
    .tx_bit_out(tx_bit), .tx_bit_valid_out(tx_bit_valid));
  phc_radio_model radio (.clk_in(clk_in), .sync_out(rx_sync),
    .bit_out(rx_bit), .bit_valid_out(rx_bit_valid), .ready_out(tx_ready),
    .tx_bit_in(tx_bit), .tx_bit_valid_in(tx_bit_valid));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // generous ceiling: the whole sequence needs under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 40000) begin
      failures++;
      complete_run();
    end
  end
  always @(posedge clk_in) begin
    if (rx_byte_valid) rxq.push_back(rx_byte);
    if (tx_pop) void'(fifoq.pop_front());
    tx_byte_valid <= fifoq.size() != 0;
    tx_byte <= (fifoq.size() != 0) ? fifoq[0] : 8'h00;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [7:0] idx, input bit we, input logic [31:0] d);
    @(posedge clk_in);
    wb_adr <= {2'b00, idx, 2'b00};
    wb_we <= we;
    wb_wdat <= d;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do @(posedge clk_in); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  function automatic logic [15:0] next_crc(input logic [15:0] c, input bit b);
    return (c << 1) ^ ((c[15] ^ b) ? poly : 16'h0000);
  endfunction
  task automatic add_byte(input logic [7:0] b, input logic l, input bit inc);
    bit x;
    for (int i = 0; i < 8; i++) begin
      x = l ? b[i] : b[7-i];
      bits.push_back(x);
      if (inc) crc_acc = next_crc(crc_acc, x);
    end
  endtask
  // header bytes 3 then 2, two payload bytes, crc msb first
  task automatic rx_frame(input logic [7:0] a, input logic [7:0] b,
                          input bit bad);
    bits.delete();
    rxq.delete();
    pay.delete();
    crc_acc = 16'h0000;
    add_byte(a, 1'b0, !donly);
    add_byte(b, 1'b0, !donly);
    repeat (2) begin
      pay.push_back(8'($urandom));
      add_byte(pay[$], 1'b0, 1'b1);
    end
    if (bad) crc_acc = 16'hffff;
    for (int i = 15; i >= 0; i--) bits.push_back(crc_acc[i]);
    // the status read lands early in the first header byte
    fork
      radio.send_bits(bits);
      begin
        repeat (4) @(posedge clk_in);
        bus(phc_pkg::IDX_STAT, 0, 0);
        check(rd & 32'h30, 32'h10);
      end
    join
    repeat (4) @(posedge clk_in);
  endtask
  initial begin
    {wb_we, wb_cyc, wb_stb, rx_en, tx_start} = 5'h00;
    {wb_adr, wb_wdat} = 44'h0;
    failures = 0;
    checked = 0;
    cycles = 0;
    void'($urandom(32'h88d6));
    srst_in = 1'b1;
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    bus(phc_pkg::IDX_CFG, 0, 0);
    check(rd, 32'h0);
    bus(phc_pkg::IDX_HCTL, 0, 0);
    check(rd, 32'h0);
    v = 8'($urandom);
    bus(phc_pkg::IDX_CFG, 1, {24'h0, v});
    bus(phc_pkg::IDX_CFG, 0, 0);
    check(rd, {24'h0, v});
    bus(phc_pkg::IDX_HCTL, 1, {24'h0, ~v});
    bus(phc_pkg::IDX_HCTL, 0, 0);
    check(rd, {24'h0, ~v});
    bus(phc_pkg::IDX_STAT, 1, 32'hff);
    bus(phc_pkg::IDX_STAT, 0, 0);
    check(rd, 32'h0);
    bus(8'h20, 0, 0);
    check(rd, 32'h0);
    $display("registers done");
    // raw receive: fifo mode with handling off, then handling on off fifo mode
    for (int k = 0; k < 2; k++) begin
      lsb = 1'($urandom);
      bus(phc_pkg::IDX_MISC, 1, k ? 32'h0 : 32'h2);
      bus(phc_pkg::IDX_CFG, 1, {24'h0, k[0], lsb, 6'h0});
      rx_en <= 1'b1;
      bits.delete();
      rxq.delete();
      pay.delete();
      repeat (3) begin
        pay.push_back(8'($urandom));
        add_byte(pay[$], lsb, 1'b0);
      end
      radio.send_bits(bits);
      repeat (3) @(posedge clk_in);
      rx_en <= 1'b0;
      check(32'(rxq.size()), 32'd3);
      foreach (pay[i]) check(32'(rxq[i]), 32'(pay[i]));
    end
    $display("raw receive done");
    c3 = 8'($urandom);
    bus(phc_pkg::IDX_MISC, 1, 32'h0222);
    bus(phc_pkg::IDX_CHK, 1, {c3, 8'($urandom), 16'h0});
    bus(phc_pkg::IDX_HCTL, 1, 32'h4c);
    for (int p = 0; p < 4; p++) begin
      donly = 1'($urandom);
      poly = POLYS[p];
      bus(phc_pkg::IDX_CFG, 1, {24'h0, 2'b10, donly, 3'b001, p[1:0]});
      rx_en <= 1'b1;
      bus(phc_pkg::IDX_STAT, 0, 0);
      check(rd & 32'h20, 32'h20);
      rx_frame(c3, 8'hff, 1'b0);
      bus(phc_pkg::IDX_STAT, 0, 0);
      check(rd & 32'h4d, 32'h08);
      bus(phc_pkg::IDX_STAT, 0, 0);
      check(rd & 32'h4d, 32'h08);
      check(32'(rxq.size()), 32'd2);
      foreach (pay[i]) check(32'(rxq[i]), 32'(pay[i]));
      bus(phc_pkg::IDX_CLR, 1, 32'h4d);
      rx_en <= 1'b0;
    end
    rx_en <= 1'b1;
    rx_frame(c3, 8'hff, 1'b1);
    bus(phc_pkg::IDX_STAT, 0, 0);
    check(rd & 32'h4d, 32'h44);
    bus(phc_pkg::IDX_CLR, 1, 32'h4d);
    rx_frame(~c3, 8'hff, 1'b0);
    check(32'(rxq.size()), 32'd0);
    bus(phc_pkg::IDX_STAT, 0, 0);
    check(rd & 32'h7d, 32'h20);
    rx_en <= 1'b0;
    $display("packet receive done");
    // raw transmit of two fifo bytes, then a packet: one header byte,
    // one payload byte and a ccitt crc
    for (int k = 0; k < 2; k++) begin
      lsb = 1'($urandom);
      h3 = 8'($urandom);
      bus(phc_pkg::IDX_MISC, 1, 32'h0112);
      bus(phc_pkg::IDX_TXH, 1, {h3, 24'h0});
      bus(phc_pkg::IDX_CFG, 1, {24'h0, 1'b0, lsb, 2'b00, k[0], k[0], 2'b00});
      bits.delete();
      radio.txq.delete();
      poly = POLYS[0];
      crc_acc = 16'h0000;
      if (k == 1) add_byte(h3, lsb, 1'b1);
      repeat (2 - k) begin
        fifoq.push_back(8'($urandom));
        add_byte(fifoq[$], lsb, 1'b1);
      end
      if (k == 1) begin
        for (int i = 15; i >= 0; i--) bits.push_back(crc_acc[i]);
      end
      repeat (2) @(posedge clk_in);
      tx_start <= 1'b1;
      @(posedge clk_in);
      tx_start <= 1'b0;
      rd = 32'h0;
      busy = 1'b0;
      while (rd[0] !== 1'b1) begin
        bus(phc_pkg::IDX_STAT, 0, 0);
        busy = busy | rd[1];
      end
      check(32'(busy), 32'(k));
      check(32'(radio.txq.size()), 32'(16 + 16 * k));
      foreach (bits[i]) check(32'(radio.txq[i]), 32'(bits[i]));
      bus(phc_pkg::IDX_CLR, 1, 32'h01);
      bus(phc_pkg::IDX_STAT, 0, 0);
      check(rd & 32'h01, 32'h0);
    end
    $display("transmit done");
    complete_run();
  end
endmodule
`default_nettype wire
